// ===== inc/shcf_link_if.sv
// three-wire serial link plus interrupt line between host and device
`timescale 1ns/1ps
interface shcf_link_if;
    logic sck;
    logic si;
    logic so;
    logic irq;
    modport host (output sck, output si, input so, input irq);
    modport device (input sck, input si, output so, output irq);
endinterface

// ===== inc/shcf_pkg.sv
// shared constants for the serial host command link
package shcf_pkg;
    localparam int SHCF_RC_W = 8;
    localparam int SHCF_RDB_DEPTH = 20;
    // return codes
    localparam logic [7:0] SHCF_RC_IDLE = 8'h00;
    localparam logic [7:0] SHCF_RC_TX_SVC = 8'h01;
    localparam logic [7:0] SHCF_RC_RX_START = 8'h04;
    localparam logic [7:0] SHCF_RC_RX_FULL = 8'h05;
    localparam logic [7:0] SHCF_RC_RX_DONE = 8'h06;
    localparam logic [7:0] SHCF_RC_RX_ABORT = 8'h07;
    localparam logic [7:0] SHCF_RC_ACCEPT = 8'h40;
    // command opcodes (arbitrary encoding)
    localparam logic [7:0] SHCF_CMD_SET_OWN_ADDR = 8'h01;
    localparam logic [7:0] SHCF_CMD_MASTER_REQ = 8'h02;
    localparam logic [7:0] SHCF_CMD_MASTER_CONT = 8'h03;
    localparam logic [7:0] SHCF_CMD_CANCEL = 8'h04;
    localparam logic [7:0] SHCF_CMD_GET_STATUS_ADDR = 8'h05;
    localparam logic [7:0] SHCF_CMD_RX_ENABLE = 8'h06;
    localparam logic [7:0] SHCF_CMD_SLAVE_DATA = 8'h07;
    localparam logic [7:0] SHCF_CMD_GET_STATE = 8'h08;
    localparam logic [7:0] SHCF_CMD_WRITE_DATA = 8'h09;
    localparam logic [7:0] SHCF_CMD_READ_DATA = 8'h0A;
    localparam logic [7:0] SHCF_CMD_READ_STATUS = 8'h0B;
    // frame bit counts and serial clock divider on the serial link
    localparam int SHCF_FRAME_BITS = 16;
    localparam int SHCF_REPLY_BITS = 8;
    localparam logic [7:0] SHCF_SCK_DIV = 8'h04;
    // status read deadlines after an aborted reception, in us and in core clock cycles
    localparam int SHCF_DEADLINE_M2_US = 290;
    localparam int SHCF_DEADLINE_M1_US = 400;
    localparam int SHCF_DEADLINE_M0_US = 1580;
    localparam int SHCF_CLK_MHZ = 100;
    localparam int SHCF_DEADLINE_M2_CYC = SHCF_DEADLINE_M2_US * SHCF_CLK_MHZ;
    localparam int SHCF_DEADLINE_M1_CYC = SHCF_DEADLINE_M1_US * SHCF_CLK_MHZ;
    localparam int SHCF_DEADLINE_M0_CYC = SHCF_DEADLINE_M0_US * SHCF_CLK_MHZ;
endpackage

// ===== testbench/shcf_link_chk.sv
// wire-level checker for the host/device serial link
`timescale 1ns/1ps
module shcf_link_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------
    // frame tracking
    // ------------------------------------------------
    // a high phase longer than five cycles marks a frame boundary
    logic [3:0] hi_run;
    logic [5:0] rises;
    always_ff @(posedge clock) begin
        if (rst || !sck) begin
            hi_run <= 4'h0;
        end else if (hi_run != 4'hF) begin
            hi_run <= hi_run + 4'h1;
        end
        if (rst || (hi_run == 4'h5 && sck)) begin
            rises <= 6'h00;
        end else if ($rose(sck)) begin
            rises <= rises + 6'h01;
        end
    end

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_sck_low_phase: assert property ($fell(sck) |-> !sck[*5] ##1 sck)
        else $error("serial clock low phase not five cycles");
    a_sck_high_phase: assert property ($rose(sck) |-> sck[*5])
        else $error("serial clock high phase too short");
    a_si_at_rise: assert property ($rose(sck) |-> $stable(si))
        else $error("data in changed at serial clock rise");
    a_frame_bit_count: assert property (
        (hi_run == 4'h5 && sck) |-> (rises == 6'h10 || rises == 6'h00))
        else $error("frame did not carry sixteen bits");
    a_reset_irq_low: assert property (
        @(posedge clock) disable iff (1'b0) rst |=> !irq)
        else $error("service request high after reset");
    a_release_idle: assert property ($fell(rst) |-> sck && !irq)
        else $error("link not idle at reset release");
    a_irq_stands: assert property ($rose(irq) |-> irq[*8])
        else $error("service request dropped too early");
    a_irq_serviced: assert property (
        $rose(irq) |-> ##[1:400] $fell(sck))
        else $error("service request not answered by a frame");
endmodule

// ===== testbench/tb_serial_host_command_flow.sv
// self-checking bench joining the host and device ends of the link
`timescale 1ns/1ps
module tb_serial_host_command_flow;
    import shcf_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b0;
    logic cmd_request = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_frame_end = 1'b0;
    logic rx_frame_error = 1'b0;
    logic tx_byte_taken = 1'b0;
    logic cmd_ready, rx_data_valid, deadline_miss, tx_byte_valid, cmd_pulse;
    logic [7:0] rx_data, last_code, tx_byte, last_cmd, cmd_arg;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] got[$];
    logic seen_start = 1'b0;

    shcf_link_if link ();
    shcf_host u_shcf_host (.link(link), .clock(clock), .rst(rst),
        .cmd_request(cmd_request), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rx_data(rx_data),
        .rx_data_valid(rx_data_valid), .last_code(last_code),
        .byte_count(), .deadline_miss(deadline_miss), .next_mode());
    shcf_device u_shcf_device (.link(link), .clock(clock), .rst(rst),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_frame_end(rx_frame_end), .rx_frame_error(rx_frame_error),
        .tx_byte_taken(tx_byte_taken), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .last_cmd(last_cmd),
        .cmd_arg(cmd_arg), .cmd_pulse(cmd_pulse));
    shcf_link_chk u_shcf_link_chk (.clock(clock), .rst(rst), .sck(link.sck),
        .si(link.si), .so(link.so), .irq(link.irq));

    initial begin
        forever #5 clock = ~clock;
    end

    // bytes the host hands out, and whether a start code was ever seen
    always @(posedge clock) begin
        if (rx_data_valid === 1'b1) got.push_back(rx_data);
        if (last_code === SHCF_RC_RX_START) seen_start = 1'b1;
    end

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic step(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic compare(string what, logic [7:0] exp, logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask

    task automatic timeout(string what);
        $display("unexpected %s: expected 1 seen 0", what);
        miscompares++;
        print_verdict();
    endtask

    // waits for the pulse of this very opcode, so service frames in between
    // cannot be mistaken for it
    task automatic send_cmd(logic [7:0] op, logic [7:0] arg);
        int i;
        cmd_op = op;
        cmd_data = arg;
        cmd_request = 1'b1;
        for (i = 0; cmd_ready !== 1'b1; i++) begin
            if (i > 3000) timeout("command taken");
            step();
        end
        step();
        cmd_request = 1'b0;
        for (i = 0; !(cmd_pulse === 1'b1 && last_cmd === op); i++) begin
            if (i > 3000) timeout("command decoded");
            step();
        end
        compare("command argument", arg, cmd_arg);
        step(300);
    endtask

    task automatic wait_code(logic [7:0] code);
        int i;
        for (i = 0; last_code !== code; i++) begin
            if (i > 4000) timeout("return code");
            step();
        end
        n_tests++;
    endtask

    task automatic push_byte(logic [7:0] b);
        step();
        rx_byte = b;
        rx_byte_valid = 1'b1;
        step();
        rx_byte_valid = 1'b0;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_idle();
        int pulses;
        pulses = 0;
        repeat (60) begin
            step();
            if (cmd_pulse === 1'b1) pulses++;
        end
        compare("frames without request", 8'h00, 8'(pulses));
        compare("idle serial clock", 8'h01, {7'h00, link.sck});
    endtask

    task automatic t_commands();
        logic [7:0] ops [7];
        logic [7:0] args [7];
        ops = '{SHCF_CMD_SET_OWN_ADDR, SHCF_CMD_MASTER_REQ, SHCF_CMD_MASTER_REQ,
            SHCF_CMD_MASTER_CONT, SHCF_CMD_GET_STATUS_ADDR,
            SHCF_CMD_SLAVE_DATA, SHCF_CMD_GET_STATE};
        args = '{8'h3C, 8'h80, 8'h00, 8'h01, 8'h00, 8'hA5, 8'h00};
        for (int k = 0; k < 7; k++) send_cmd(ops[k], args[k]);
    endtask

    task automatic t_write_cancel();
        send_cmd(SHCF_CMD_WRITE_DATA, 8'h5A);
        compare("write buffer byte", 8'h5A, tx_byte);
        send_cmd(SHCF_CMD_CANCEL, 8'h00);
        compare("write buffer after cancel", 8'h00, {7'h00, tx_byte_valid});
        send_cmd(SHCF_CMD_WRITE_DATA, 8'hC3);
        compare("write buffer loaded", 8'h01, {7'h00, tx_byte_valid});
        tx_byte_taken = 1'b1;
        step();
        tx_byte_taken = 1'b0;
        step();
        compare("write buffer after send", 8'h00, {7'h00, tx_byte_valid});
    endtask

    task automatic rx_frame(logic [7:0] base, int n, logic err);
        int i;
        got.delete();
        for (int k = 0; k < n; k++) push_byte(base + 8'(k));
        if (n == SHCF_RDB_DEPTH) wait_code(SHCF_RC_RX_FULL);
        step();
        rx_frame_end = !err;
        rx_frame_error = err;
        step();
        rx_frame_end = 1'b0;
        rx_frame_error = 1'b0;
        wait_code(err ? SHCF_RC_RX_ABORT : SHCF_RC_RX_DONE);
        for (i = 0; got.size() < n; i++) begin
            if (i > 20000) timeout("received bytes");
            step();
        end
        step(800);
        compare("received count", 8'(n), 8'(got.size()));
        for (int k = 0; k < n; k++) compare("received byte", base + 8'(k), got[k]);
    endtask

    task automatic t_receive();
        send_cmd(SHCF_CMD_RX_ENABLE, 8'h01);
        rx_frame(8'h10, SHCF_RDB_DEPTH, 1'b0);
        compare("start code seen", 8'h01, {7'h00, seen_start});
        rx_frame(8'hE0, 3, 1'b1);
        compare("status deadline missed", 8'h00, {7'h00, deadline_miss});
        send_cmd(SHCF_CMD_RX_ENABLE, 8'h00);
        got.delete();
        push_byte(8'h77);
        step(800);
        compare("bytes while disabled", 8'h00, 8'(got.size()));
    endtask

    initial begin
        #1 rst = 1'b1;
        step(8);
        rst = 1'b0;
        t_idle();
        t_commands();
        t_write_cancel();
        t_receive();
        print_verdict();
    end
endmodule

// ===== verilog/shcf_device.sv
// device end: serial command decoder, return code and receive buffer
`timescale 1ns/1ps
module shcf_device
    import shcf_pkg::*;
#(
    parameter int RDB_DEPTH = SHCF_RDB_DEPTH
) (
    shcf_link_if.device link,
    input wire logic clock,
    input wire logic rst,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic rx_frame_error,
    input wire logic tx_byte_taken,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    output logic [7:0] last_cmd,
    output logic [7:0] cmd_arg,
    output logic cmd_pulse
);
    // ------------------------------------------------------------
    // link domain: shift register on the host's serial clock
    // ------------------------------------------------------------
    // frame: 8-bit opcode then 8-bit argument, msb first; reply on so
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0] count;
        logic [7:0] reply;
        logic toggle;
        logic [15:0] word;
    } shcf_lk_type;
    shcf_lk_type lk, next_lk;
    // sck stands still while rst is high, so this side resets without an edge
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // ------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tog_sync;
        logic [7:0] ret_code;
        logic [4:0] rd_ptr;
        logic [4:0] wr_ptr;
        logic [5:0] level;
        logic [4:0] fill;
        logic rx_enabled;
        logic irq;
        logic [7:0] wdb_data;
        logic wdb_valid;
        logic [7:0] cmd;
        logic [7:0] arg;
        logic pulse;
    } shcf_dv_type;
    shcf_dv_type dv, next_dv;
    logic [7:0] read_data_buffer [RDB_DEPTH];
    logic [15:0] word_core;
    logic rdb_write;
    logic irq_set;
    logic got_frame;
    assign word_core = lk.word; // stable: sampled after toggle sync
    assign got_frame = dv.tog_sync[2] ^ dv.tog_sync[1];
    always_comb begin
        next_dv = dv;
        next_dv.tog_sync = {dv.tog_sync[1:0], lk.toggle};
        next_dv.pulse = 1'b0;
        rdb_write = 1'b0;
        irq_set = 1'b0;
        if (tx_byte_taken) begin
            next_dv.wdb_valid = 1'b0;
        end
        if (rx_byte_valid && dv.rx_enabled && dv.level < 6'(RDB_DEPTH)) begin
            rdb_write = 1'b1;
            next_dv.wr_ptr = (dv.wr_ptr == 5'(RDB_DEPTH - 1)) ? 5'd0
                : dv.wr_ptr + 5'd1;
            next_dv.level = dv.level + 6'd1;
            next_dv.fill = dv.fill + 5'd1;
            if (dv.fill == 5'(RDB_DEPTH - 1)) begin
                next_dv.fill = 5'd0;
                next_dv.ret_code = SHCF_RC_RX_FULL;
                next_dv.irq = 1'b1;
                irq_set = 1'b1;
            end
        end
        if (rx_frame_end && dv.rx_enabled) begin
            next_dv.ret_code = SHCF_RC_RX_DONE;
            next_dv.irq = 1'b1;
            irq_set = 1'b1;
        end else if (rx_frame_error && dv.rx_enabled) begin
            next_dv.ret_code = SHCF_RC_RX_ABORT;
            next_dv.irq = 1'b1;
            irq_set = 1'b1;
        end
        if (got_frame) begin
            next_dv.cmd = word_core[15:8];
            next_dv.arg = word_core[7:0];
            next_dv.pulse = 1'b1;
            case (word_core[15:8])
                SHCF_CMD_READ_STATUS: begin
                    // an event in this very cycle keeps the request up
                    next_dv.irq = irq_set;
                end
                SHCF_CMD_READ_DATA: begin
                    if (dv.level != 6'd0) begin
                        next_dv.rd_ptr = (dv.rd_ptr == 5'(RDB_DEPTH - 1))
                            ? 5'd0 : dv.rd_ptr + 5'd1;
                        next_dv.level = next_dv.level - 6'd1;
                    end
                end
                SHCF_CMD_MASTER_REQ, SHCF_CMD_MASTER_CONT: begin
                    // msb set means transmit, clear means receive
                    if (word_core[7]) begin
                        next_dv.ret_code = SHCF_RC_TX_SVC;
                    end else begin
                        next_dv.ret_code = SHCF_RC_RX_START;
                        next_dv.fill = 5'd0;
                    end
                    next_dv.irq = 1'b1;
                end
                SHCF_CMD_CANCEL: begin
                    next_dv.wdb_valid = 1'b0;
                    next_dv.ret_code = SHCF_RC_IDLE;
                end
                SHCF_CMD_RX_ENABLE: begin
                    next_dv.rx_enabled = word_core[0];
                end
                SHCF_CMD_WRITE_DATA: begin
                    next_dv.wdb_data = word_core[7:0];
                    next_dv.wdb_valid = 1'b1;
                end
                SHCF_CMD_SLAVE_DATA: begin
                    next_dv.ret_code = SHCF_RC_TX_SVC;
                    next_dv.irq = 1'b1;
                end
                default: begin
                    next_dv.pulse = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            dv <= '0;
        end else begin
            dv <= next_dv;
        end
        if (rdb_write) begin
            read_data_buffer[dv.wr_ptr] <= rx_byte;
        end
    end
    // ------------------------------------------------------------
    // link domain: frame shifter and reply
    // ------------------------------------------------------------
    // bit 4 of a status reply flags bytes still waiting in the buffer
    localparam logic [7:0] DATA_WAITING = 8'h10;
    logic [7:0] status_reply;
    assign status_reply = dv.ret_code
        | ((dv.level != 6'd0) ? DATA_WAITING : 8'h00);
    always_comb begin
        next_lk = lk;
        next_lk.shift = {lk.shift[14:0], link.si};
        next_lk.reply = {lk.reply[6:0], 1'b0};
        next_lk.count = lk.count + 5'd1;
        // the opcode completes on the eighth rise and the answer goes out
        // in the argument half; the read pointer only moves just after a
        // frame ends, while return code and level also move on receive events
        if (lk.count == 5'd7) begin
            case ({lk.shift[6:0], link.si})
                SHCF_CMD_READ_STATUS: next_lk.reply = status_reply;
                SHCF_CMD_READ_DATA: next_lk.reply = read_data_buffer[dv.rd_ptr];
                default: next_lk.reply = SHCF_RC_ACCEPT;
            endcase
        end
        if (lk.count == 5'(SHCF_FRAME_BITS - 1)) begin
            next_lk.count = 5'd0;
            next_lk.word = {lk.shift[14:0], link.si};
            next_lk.toggle = ~lk.toggle;
        end
    end
    assign link.so = lk.reply[7];
    assign link.irq = dv.irq;
    assign tx_byte = dv.wdb_data;
    assign tx_byte_valid = dv.wdb_valid;
    assign last_cmd = dv.cmd;
    assign cmd_arg = dv.arg;
    assign cmd_pulse = dv.pulse;
endmodule

// ===== verilog/shcf_host.sv
// host end: command issue, interrupt service and data handling
`timescale 1ns/1ps
// Summary of operation
// - control only through three-wire serial port
// - commands start only when request flag set; irq status and data reads start without cmd_request
// - irq high means read code, service
// - master transmit: code top bits 00 refills
// - slave transmit: code top bits 00 refills
// - partial transmit then continue or cancel
// - cancel discards untransmitted write buffer data
// - codes 4H, 5H start and full
// - codes 6H, 7H normal and aborted end
// - one serial clock burst per single read
// - aborted reception: read status before deadline
// - deadline lifted while reception disabled
// - slave and broadcast share receive handling
// - command set issued from command routine
// - control msb selects transmit or receive
// - twenty-byte receive buffer, full raises irq
module shcf_host
    import shcf_pkg::*;
(
    shcf_link_if.host link,
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_request,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic [7:0] rx_data,
    output logic rx_data_valid,
    output logic [7:0] last_code,
    output logic [7:0] byte_count,
    output logic deadline_miss,
    output logic [1:0] next_mode
);
    typedef enum logic [2:0] {
        SHCF_IDLE = 3'b000,
        SHCF_SHIFT = 3'b001,
        SHCF_STATUS = 3'b010,
        SHCF_DATA = 3'b011,
        SHCF_GAP = 3'b100
    } shcf_state_type;
    typedef struct packed {
        shcf_state_type state;
        shcf_state_type after;
        logic [15:0] shift;
        logic [7:0] reply;
        logic [4:0] bits;
        logic [7:0] div;
        logic sck;
        logic [1:0] irq_sync;
        logic [7:0] code;
        logic [7:0] count;
        logic [7:0] rx;
        logic rx_valid;
        logic rx_disabled;
        logic [20:0] timer;
        logic armed;
        logic miss;
    } shcf_hs_type;
    shcf_hs_type hs, next_hs;
    // bit 4 of a status reply flags bytes still waiting in the buffer
    localparam logic [7:0] DATA_WAITING = 8'h10;
    logic [1:0] so_sync;
    logic frame_done;
    always_ff @(posedge clock) begin
        if (rst) begin
            so_sync <= 2'b00;
        end else begin
            so_sync <= {so_sync[0], link.so};
        end
    end
    assign frame_done = hs.div == 8'h00 && hs.sck
        && hs.bits == 5'(SHCF_FRAME_BITS - 1);
    always_comb begin
        next_hs = hs;
        next_hs.irq_sync = {hs.irq_sync[0], link.irq};
        next_hs.rx_valid = 1'b0;
        // serial clock is divided from the core clock; host owns the link
        if (hs.state == SHCF_SHIFT) begin
            next_hs.div = hs.div - 8'h01;
            if (hs.div == 8'h00) begin
                next_hs.div = SHCF_SCK_DIV;
                if (!hs.sck) begin
                    next_hs.sck = 1'b1;
                    next_hs.reply = {hs.reply[6:0], so_sync[1]};
                end else if (hs.bits != 5'(SHCF_FRAME_BITS - 1)) begin
                    // falling edge: present next bit; the frame ends high
                    next_hs.sck = 1'b0;
                    next_hs.shift = {hs.shift[14:0], 1'b0};
                    next_hs.bits = hs.bits + 5'd1;
                end
            end
        end
        if (hs.armed) begin
            next_hs.timer = hs.timer - 21'd1;
            if (hs.timer == 21'd0) begin
                next_hs.miss = 1'b1;
                next_hs.armed = 1'b0;
            end
        end
        case (hs.state)
            SHCF_IDLE: begin
                if (hs.irq_sync[1]) begin
                    next_hs.shift = {SHCF_CMD_READ_STATUS, 8'h00};
                    next_hs.after = SHCF_STATUS;
                    next_hs.state = SHCF_SHIFT;
                    next_hs.bits = 5'd0;
                    next_hs.sck = 1'b0;
                    next_hs.div = SHCF_SCK_DIV;
                end else if (cmd_request) begin
                    next_hs.shift = {cmd_op, cmd_data};
                    if (cmd_op == SHCF_CMD_RX_ENABLE) begin
                        next_hs.rx_disabled = ~cmd_data[0];
                    end
                    if (cmd_op == SHCF_CMD_MASTER_REQ
                        || cmd_op == SHCF_CMD_CANCEL) begin
                        next_hs.count = 8'h00;
                    end
                    next_hs.after = SHCF_GAP;
                    next_hs.state = SHCF_SHIFT;
                    next_hs.bits = 5'd0;
                    next_hs.sck = 1'b0;
                    next_hs.div = SHCF_SCK_DIV;
                end
            end
            SHCF_SHIFT: begin
                if (frame_done) begin
                    next_hs.state = hs.after;
                end
            end
            SHCF_STATUS: begin
                // the reply rides in the argument half of the same frame
                next_hs.code = hs.reply & ~DATA_WAITING;
                next_hs.armed = 1'b0;
                next_hs.miss = 1'b0;
                next_hs.state = SHCF_GAP;
                case (hs.reply & ~DATA_WAITING)
                    SHCF_RC_RX_FULL, SHCF_RC_RX_DONE, SHCF_RC_RX_ABORT: begin
                        if ((hs.reply & DATA_WAITING) != 8'h00) begin
                            next_hs.shift = {SHCF_CMD_READ_DATA, 8'h00};
                            next_hs.after = SHCF_DATA;
                            next_hs.state = SHCF_SHIFT;
                            next_hs.bits = 5'd0;
                            next_hs.sck = 1'b0;
                            next_hs.div = SHCF_SCK_DIV;
                        end
                    end
                    SHCF_RC_RX_START: begin
                        next_hs.count = 8'h00;
                    end
                    default: begin
                        if (hs.reply[7:6] == 2'b00) begin
                            next_hs.count = hs.count + 8'h01;
                        end
                    end
                endcase
            end
            SHCF_DATA: begin
                next_hs.rx = hs.reply;
                next_hs.rx_valid = 1'b1;
                next_hs.count = hs.count + 8'h01;
                // status again at once: drains the buffer byte by byte and
                // keeps the read after an aborted reception well in time
                next_hs.shift = {SHCF_CMD_READ_STATUS, 8'h00};
                next_hs.after = SHCF_STATUS;
                next_hs.state = SHCF_SHIFT;
                next_hs.bits = 5'd0;
                next_hs.sck = 1'b0;
                next_hs.div = SHCF_SCK_DIV;
                if (hs.code == SHCF_RC_RX_ABORT && !hs.rx_disabled) begin
                    next_hs.armed = 1'b1;
                    next_hs.timer = 21'(SHCF_DEADLINE_M0_CYC);
                end
            end
            SHCF_GAP: begin
                next_hs.sck = 1'b1;
                next_hs.state = SHCF_IDLE;
            end
            default: begin
                next_hs.state = SHCF_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            hs <= '0;
            hs.sck <= 1'b1;
            hs.div <= SHCF_SCK_DIV;
        end else begin
            hs <= next_hs;
        end
    end
    assign link.sck = hs.sck;
    assign link.si = hs.shift[15];
    assign cmd_ready = hs.state == SHCF_IDLE && !hs.irq_sync[1];
    assign rx_data = hs.rx;
    assign rx_data_valid = hs.rx_valid;
    assign last_code = hs.code;
    assign byte_count = hs.count;
    assign deadline_miss = hs.miss;
    assign next_mode = 2'b00;
endmodule
